// ==== pfm_checker.sv ====
// Purpose: port assertions of pfm_top
// Assumes: one clock, async low reset
// Notes:   bound into pfm_top below
`timescale 1ns/1ns
`default_nettype none
module pfm_checker #(
    parameter NPAIRS = 3
) (
    // clock, reset and register handshake
    input wire logic              core_clk_in,
    input wire logic              resetn_in,
    input wire logic              avs_read_in,
    input wire logic              avs_write_in,
    input wire logic              avs_waitrequest_out,
    // pair flags and controls
    input wire logic [NPAIRS-1:0] signal_loss_in,
    input wire logic [NPAIRS-1:0] frame_alignment_loss_in,
    input wire logic [NPAIRS-1:0] activated_in,
    input wire logic [NPAIRS-1:0] pair_id_ok_in,
    input wire logic [NPAIRS-1:0] startup_req_out,
    input wire logic [NPAIRS-1:0] loopback_out,
    input wire logic              loopback_req_in,
    // maintenance channel
    input wire logic              eoc_valid_in,
    input wire logic [7:0]        eoc_in,
    input wire logic              eoc_valid_out,
    input wire logic [NPAIRS*8-1:0] eoc_out,
    // mapping and section state
    input wire logic [31:0]       map_out,
    input wire logic              map_change_out,
    input wire logic              operational_out,
    // slot stream
    input wire logic              slot_valid_in,
    input wire logic [4:0]        slot_idx_in,
    input wire logic [7:0]        slot_data_in,
    input wire logic              slot_valid_out,
    input wire logic [4:0]        slot_idx_out,
    input wire logic [7:0]        slot_data_out,
    input wire logic              slot_ais_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // one wait per request
    a_one_wait: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("wait timing");
    // eoc byte on every pair
    a_eoc_copy: assert property (
        eoc_valid_in |=> eoc_valid_out && eoc_out == {NPAIRS{$past(eoc_in)}})
        else $error("eoc copy");
    // operational needs good pairs
    a_oper_cause: assert property (
        operational_out |-> $past(&activated_in && &pair_id_ok_in))
        else $error("bad operational");
    // loss or bad id drops it
    a_nonoper_loss: assert property (
        (|(signal_loss_in | frame_alignment_loss_in) || !(&pair_id_ok_in)) |=> !operational_out)
        else $error("stays operational");
    // loopback uniform, on request
    a_loop_all: assert property (
        (|loopback_out) |-> (&loopback_out) && $past(loopback_req_in))
        else $error("bad loopback");
    // slots keep place and data
    a_slot_pass: assert property (
        slot_valid_in |=> slot_valid_out && slot_idx_out == $past(slot_idx_in)
        && (slot_ais_out || slot_data_out == $past(slot_data_in))) else $error("slot altered");
    // alarm slots hold all ones
    a_ais_ones: assert property (
        slot_valid_out && slot_ais_out |-> slot_data_out == 8'hFF) else $error("alarm not ones");
    // alarm follows mask
    a_ais_mask: assert property (
        slot_valid_out |-> slot_ais_out == !map_out[slot_idx_out]) else $error("alarm vs mask");
    // change pulse only on change
    a_map_change: assert property (
        map_change_out |-> map_out != $past(map_out)) else $error("false change");
    // retries spaced out
    a_retry_gap: assert property (
        startup_req_out[0] |=> (!startup_req_out[0]) [*8]) else $error("retry too soon");
endmodule
bind pfm_top pfm_checker #(.NPAIRS(NPAIRS)) u_chk (.*);
`default_nettype wire

// ==== pfm_consts.vh ====
// Purpose: constants of the pfm block
// Assumes: included by bare name
// Notes:   offsets are byte addresses
`ifndef PFM_CONSTS_VH
`define PFM_CONSTS_VH

// register byte offsets
`define PFM_OFS_CTRL          4'h0
`define PFM_OFS_STATUS        4'h4
`define PFM_OFS_PRIO          4'h8
`define PFM_OFS_MAP           4'hC

// control register fields
`define PFM_CTRL_LOOP_BIT     0
`define PFM_CTRL_MASTER_BIT   1
`define PFM_CTRL_PRIO_BIT     2
`define PFM_CTRL_MODE_LO      3
`define PFM_CTRL_MODE_HI      4
`define PFM_CTRL_RESET        32'h0000_0002

// status register fields
`define PFM_STAT_FAIL_LO      0
`define PFM_STAT_OPER_BIT     8
`define PFM_STAT_SWL_LO       16

// priority register reset value
`define PFM_PRIO_RESET        32'h0000_0000

// reallocation modes
`define PFM_MODE_TSI          2'h0
`define PFM_MODE_CORE         2'h1
`define PFM_MODE_PAIR         2'h2

// time slot layout of the application frame
`define PFM_SLOTS             32
`define PFM_SLOT_ALIGN        5'h00
`define PFM_SLOT_SIGNAL       5'h10
`define PFM_AIS_BYTE          8'hFF

// start-up retry interval
`define PFM_CLK_MHZ           250
`define PFM_RETRY_TIME_US     1000
`define PFM_RETRY_CYCLES      (`PFM_RETRY_TIME_US * `PFM_CLK_MHZ)

`endif

// ==== pfm_pair_mon.v ====
// Purpose: failure flag and retry of one pair
// Assumes: transceiver flags come from logic on core_clk_in
// Notes:   one instance per pair
`timescale 1ns/1ns
`default_nettype none
module pfm_pair_mon #(
    parameter RETRY_CYCLES = 250000
) (
    // clock and reset
    input  wire core_clk_in,
    input  wire resetn_in,
    // transceiver activation flags
    input  wire signal_loss_in,
    input  wire frame_alignment_loss_in,
    input  wire sync_word_loss_in,
    input  wire activated_in,
    // software clear of the sticky sync word loss bit
    input  wire swl_clear_in,
    // status towards the mapping logic
    output reg  fail_out,
    output reg  startup_req_out,
    output reg  swl_seen_out
);
    localparam CW = $clog2(RETRY_CYCLES + 1);

    reg  [CW-1:0] retry_cnt;   // cycles to next attempt
    wire          fail_set;    // hard failure seen this cycle

    // sync word loss alone is only noise, never a failure
    assign fail_set = signal_loss_in | frame_alignment_loss_in;

    // failure flag: set by loss, cleared on reactivation
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fail_out <= 1'b0;
        end else if (fail_set) begin
            fail_out <= 1'b1;
        end else if (activated_in) begin
            fail_out <= 1'b0;
        end
    end

    // start-up retry while failed and down
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            retry_cnt       <= {CW{1'b0}};
            startup_req_out <= 1'b0;
        end else if (fail_out && !activated_in) begin
            if (retry_cnt == {CW{1'b0}}) begin
                startup_req_out <= 1'b1;
                retry_cnt       <= RETRY_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            end else begin
                startup_req_out <= 1'b0;
                retry_cnt       <= retry_cnt - {{(CW-1){1'b0}}, 1'b1};
            end
        end else begin
            // first attempt right after a failure
            startup_req_out <= 1'b0;
            retry_cnt       <= {CW{1'b0}};
        end
    end

    // sticky sync word loss, set beats clear
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            swl_seen_out <= 1'b0;
        end else if (sync_word_loss_in) begin
            swl_seen_out <= 1'b1;
        end else if (swl_clear_in) begin
            swl_seen_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== pfm_slot_fill.v ====
// Purpose: pass or alarm-fill each slot
// Assumes: one byte per valid cycle
// Notes:   mask may change at slot 0
`timescale 1ns/1ns
`default_nettype none
`include "pfm_consts.vh"
module pfm_slot_fill (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        resetn_in,
    // carried slot mask, one bit per slot
    input  wire [31:0] carried_in,
    // slot stream in
    input  wire        slot_valid_in,
    input  wire [4:0]  slot_idx_in,
    input  wire [7:0]  slot_data_in,
    // slot stream out
    output reg         slot_valid_out,
    output reg  [4:0]  slot_idx_out,
    output reg  [7:0]  slot_data_out,
    output reg         slot_ais_out
);
    // keep position, replace content of uncarried slots
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slot_valid_out <= 1'b0;
            slot_idx_out   <= 5'h00;
            slot_data_out  <= 8'h00;
            slot_ais_out   <= 1'b0;
        end else begin
            slot_valid_out <= slot_valid_in;
            slot_idx_out   <= slot_idx_in;
            if (slot_valid_in && !carried_in[slot_idx_in]) begin
                slot_data_out <= `PFM_AIS_BYTE;
                slot_ais_out  <= 1'b1;
            end else begin
                slot_data_out <= slot_data_in;
                slot_ais_out  <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== pfm_tb.sv ====
// Purpose: bench of pfm_top
// Assumes: three pairs, short retry
// Notes:   fixed-seed random data
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam NP = 3;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] avs_address_in, avs_byteenable_in;
    logic avs_read_in, avs_write_in, eoc_valid_in, loopback_req_in, slot_valid_in;
    logic [31:0] avs_writedata_in, remote_map_in, rd, seed, pr;
    logic [7:0] eoc_in, slot_data_in;
    logic [4:0] slot_idx_in;
    logic [NP-1:0] cut_los, cut_lfa, noise, id_bad;
    wire [31:0] avs_readdata_out, map_out;
    wire avs_waitrequest_out, eoc_valid_out, map_change_out, operational_out;
    wire slot_valid_out, slot_ais_out;
    wire [4:0] slot_idx_out;
    wire [7:0] slot_data_out;
    wire [NP*8-1:0] eoc_out;
    wire [NP-1:0] signal_loss_in, frame_alignment_loss_in, sync_word_loss_in;
    wire [NP-1:0] activated_in, pair_id_ok_in, startup_req_out, loopback_out;
    int n_errors = 0;
    int comparisons = 0;
    int n;
    always #2 core_clk_in = ~core_clk_in;
    pfm_top #(.NPAIRS(NP), .RETRY_CYCLES(16)) dut (.*);
    pfm_xcvr_model #(.NP(NP)) xcvr (.clk_in(core_clk_in), .resetn_in(resetn_in),
        .cut_los_in(cut_los), .cut_lfa_in(cut_lfa), .noise_in(noise), .id_bad_in(id_bad),
        .startup_req_in(startup_req_out), .signal_loss_out(signal_loss_in),
        .frame_alignment_loss_out(frame_alignment_loss_in),
        .sync_word_loss_out(sync_word_loss_in), .pair_id_ok_out(pair_id_ok_in),
        .activated_out(activated_in));
    // random step
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    // carried mask with pairs f failed
    function automatic logic [31:0] home(input logic [2:0] f);
        for (int s = 0; s < 32; s++)
            home[s] = (s == 0 || s == 16) ? ~&f : !f[(s < 16 ? s - 1 : s - 17) % 3];
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one access, held until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 20);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (k >= 20) begin
            n_errors++;
            print_verdict();
        end
    endtask
    // one random frame checked against m
    task automatic frame(input logic [31:0] m);
        logic [7:0] d [32];
        for (int s = 0; s <= 32; s++) begin
            @(posedge core_clk_in);
            seed = nxt(seed);
            if (s < 32) begin
                d[s] = seed[7:0];
                slot_idx_in <= s[4:0];
                slot_data_in <= seed[7:0];
            end
            slot_valid_in <= (s < 32);
            @(negedge core_clk_in);
            if (s > 0) begin
                chk("slot_valid", slot_valid_out, 1);
                chk("slot_idx", slot_idx_out, s - 1);
                chk("slot_data", slot_data_out, m[s-1] ? d[s-1] : 8'hFF);
                chk("slot_ais", slot_ais_out, !m[s-1]);
            end
        end
        chk("map", map_out, m);
    endtask
    // poll until no pair failed
    task automatic await_up;
        int k;
        k = 0;
        do begin
            bus(1'b0, 4'h4, 32'h0);
            k++;
        end while (rd[2:0] !== 3'h0 && k < 30);
        chk("fail_bits", rd[2:0], 0);
    endtask
    // random maintenance bytes, valid when seed[9] is set
    always @(posedge core_clk_in) begin
        eoc_valid_in <= seed[9];
        eoc_in <= seed[23:16];
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge core_clk_in);
        n_errors++;
        print_verdict();
    end
    initial begin
        {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = 0;
        {slot_valid_in, slot_idx_in, slot_data_in, loopback_req_in} = 0;
        {cut_los, cut_lfa, noise, id_bad} = 0;
        avs_byteenable_in = 4'hF;
        remote_map_in = 32'h0;
        seed = 32'h88422DE7;
        repeat (6) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl", rd, 32'h2);
        bus(1'b0, 4'h8, 32'h0);
        chk("prio", rd, 32'h0);
        bus(1'b0, 4'hC, 32'h0);
        chk("map_reg", rd, 32'hFFFFFFFF);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("operational", operational_out, 1);
        $display("test reset done");
        // sync word loss only recorded
        noise <= 3'h2;
        @(posedge core_clk_in);
        noise <= 3'h0;
        bus(1'b0, 4'h4, 32'h0);
        chk("fail_bits", rd[2:0], 0);
        chk("swl_bits", rd[18:16], 3'h2);
        bus(1'b1, 4'h4, 32'h0002_0000);
        bus(1'b0, 4'h4, 32'h0);
        chk("swl_bits", rd[18:16], 0);
        id_bad <= 3'h2;
        repeat (3) @(posedge core_clk_in);
        chk("operational", operational_out, 0);
        id_bad <= 3'h0;
        repeat (3) @(posedge core_clk_in);
        chk("operational", operational_out, 1);
        $display("test sync and id done");
        // each pair fails and recovers
        seed = nxt(seed);
        bus(1'b1, 4'h0, 32'h6);
        bus(1'b1, 4'h8, seed);
        for (int p = 0; p < NP; p++) begin
            if (p == 1) cut_lfa[p] <= 1'b1;
            else cut_los[p] <= 1'b1;
            n = 0;
            repeat (40) begin
                @(posedge core_clk_in);
                n += startup_req_out[p];
            end
            chk("retries", n >= 2, 1);
            chk("operational", operational_out, 0);
            frame(home(3'h1 << p));
            cut_los <= 3'h0;
            cut_lfa <= 3'h0;
            await_up();
            frame(32'hFFFFFFFF);
        end
        $display("test pair failures done");
        // master priority reallocation
        pr = nxt(seed);
        bus(1'b1, 4'h8, pr);
        bus(1'b1, 4'h0, 32'hE);
        cut_los[2] <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        frame(pr | 32'h00010001);
        cut_los <= 3'h0;
        await_up();
        // follower copies the master's mask
        remote_map_in <= nxt(pr);
        bus(1'b1, 4'h0, 32'h10);
        frame(nxt(pr));
        $display("test reallocation done");
        // loopback only from the line end
        bus(1'b1, 4'h0, 32'h3);
        loopback_req_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        chk("loopback", loopback_out, 3'h7);
        bus(1'b1, 4'h0, 32'h1);
        repeat (3) @(posedge core_clk_in);
        chk("loopback", loopback_out, 3'h0);
        $display("test loopback done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== pfm_top.v ====
// Purpose: pair failure mapping and maintenance
// Assumes: all neighbours on core_clk_in
// Notes:   registers over Avalon-MM with one fixed wait state
`timescale 1ns/1ns
`default_nettype none
`include "pfm_consts.vh"
module pfm_top #(
    parameter NPAIRS       = 3,
    parameter RETRY_CYCLES = `PFM_RETRY_CYCLES
) (
    // clock and reset
    input  wire                  core_clk_in,
    input  wire                  resetn_in,
    // avalon-mm slave
    input  wire [3:0]            avs_address_in,
    input  wire                  avs_read_in,
    input  wire                  avs_write_in,
    input  wire [31:0]           avs_writedata_in,
    input  wire [3:0]            avs_byteenable_in,
    output reg  [31:0]           avs_readdata_out,
    output reg                   avs_waitrequest_out,
    // per-pair transceiver flags
    input  wire [NPAIRS-1:0]     signal_loss_in,
    input  wire [NPAIRS-1:0]     frame_alignment_loss_in,
    input  wire [NPAIRS-1:0]     sync_word_loss_in,
    input  wire [NPAIRS-1:0]     activated_in,
    input  wire [NPAIRS-1:0]     pair_id_ok_in,
    // per-pair transceiver controls
    output wire [NPAIRS-1:0]     startup_req_out,
    output reg  [NPAIRS-1:0]     loopback_out,
    // maintenance channel
    input  wire                  eoc_valid_in,
    input  wire [7:0]            eoc_in,
    output reg                   eoc_valid_out,
    output reg  [NPAIRS*8-1:0]   eoc_out,
    // application interface requests
    input  wire                  loopback_req_in,
    // mapping exchange between line and network end
    input  wire [31:0]           remote_map_in,
    output reg  [31:0]           map_out,
    output reg                   map_change_out,
    output reg                   operational_out,
    // time slot stream
    input  wire                  slot_valid_in,
    input  wire [4:0]            slot_idx_in,
    input  wire [7:0]            slot_data_in,
    output wire                  slot_valid_out,
    output wire [4:0]            slot_idx_out,
    output wire [7:0]            slot_data_out,
    output wire                  slot_ais_out
);
    // control and priority registers
    reg  [31:0]       ctrl;          // loopback gate, role, priority, mode
    reg  [31:0]       prio;          // one high-priority bit per slot
    reg  [31:0]       next_ctrl;     // byte-lane merge of a write
    reg  [31:0]       next_prio;     // byte-lane merge of a write
    reg  [31:0]       rd_word;       // read mux result
    reg  [31:0]       status_word;   // assembled status
    reg  [31:0]       next_map;      // mask the frame should carry
    wire [NPAIRS-1:0] fail;          // per-pair failure bits
    wire [NPAIRS-1:0] swl_seen;      // sticky sync word loss bits
    reg  [NPAIRS-1:0] swl_clear;     // software clear of those bits
    wire [31:0]       local_map;     // mask computed at this end
    wire [31:0]       carried_now;   // mask for this slot
    wire              any_up;        // at least one pair still carrying
    wire              any_fail;      // at least one pair failed
    wire              is_master;     // this end is the line termination
    wire [1:0]        mode;          // reallocation point
    wire              prio_en;       // priority reallocation enabled
    wire              frame_start;   // first slot of a frame seen
    wire              bus_req;       // read or write pending

    assign is_master   = ctrl[`PFM_CTRL_MASTER_BIT];
    assign prio_en     = ctrl[`PFM_CTRL_PRIO_BIT];
    assign mode        = ctrl[`PFM_CTRL_MODE_HI:`PFM_CTRL_MODE_LO];
    assign any_fail    = |fail;
    assign any_up      = ~&fail;
    assign frame_start = slot_valid_in && (slot_idx_in == `PFM_SLOT_ALIGN);
    assign bus_req     = avs_read_in | avs_write_in;
    assign carried_now = frame_start ? next_map : map_out;

    // home pair of a data slot
    function integer home_pair;
        input integer s;
        begin
            if (s < 16) begin
                home_pair = (s - 1) % NPAIRS;
            end else begin
                home_pair = (s - 17) % NPAIRS;
            end
        end
    endfunction

    // one independent monitor per pair
    genvar p;
    generate
        for (p = 0; p < NPAIRS; p = p + 1) begin : g_pair
            pfm_pair_mon #(
                .RETRY_CYCLES            (RETRY_CYCLES)
            ) u_mon (
                .core_clk_in             (core_clk_in),
                .resetn_in               (resetn_in),
                .signal_loss_in          (signal_loss_in[p]),
                .frame_alignment_loss_in (frame_alignment_loss_in[p]),
                .sync_word_loss_in       (sync_word_loss_in[p]),
                .activated_in            (activated_in[p]),
                .swl_clear_in            (swl_clear[p]),
                .fail_out                (fail[p]),
                .startup_req_out         (startup_req_out[p]),
                .swl_seen_out            (swl_seen[p])
            );
        end
    endgenerate

    // carried mask per slot from the pair failure bits
    genvar s;
    generate
        for (s = 0; s < `PFM_SLOTS; s = s + 1) begin : g_slot
            if (s == 0 || s == 16) begin : g_mnt
                // alignment and signalling slots ride on all pairs
                assign local_map[s] = any_up;
            end else begin : g_data
                // priority slots move, the rest yield
                assign local_map[s] =
                    (prio_en && any_fail && mode != `PFM_MODE_TSI) ?
                    (prio[s] & any_up) :
                    ~fail[home_pair(s)];
            end
        end
    endgenerate

    // master, or any end in TSI mode, decides; follower copies
    always @* begin
        if (is_master || mode == `PFM_MODE_TSI) begin
            next_map = local_map;
        end else begin
            next_map = remote_map_in & {32{any_up}};
        end
    end

    // mask latched per frame, never split
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            map_out        <= 32'hFFFF_FFFF;
            map_change_out <= 1'b0;
        end else if (frame_start) begin
            map_out        <= next_map;
            map_change_out <= (next_map != map_out) && is_master;
        end else begin
            map_change_out <= 1'b0;
        end
    end

    // alarm filling of the application-side slot stream
    pfm_slot_fill u_fill (
        .core_clk_in    (core_clk_in),
        .resetn_in      (resetn_in),
        .carried_in     (carried_now),
        .slot_valid_in  (slot_valid_in),
        .slot_idx_in    (slot_idx_in),
        .slot_data_in   (slot_data_in),
        .slot_valid_out (slot_valid_out),
        .slot_idx_out   (slot_idx_out),
        .slot_data_out  (slot_data_out),
        .slot_ais_out   (slot_ais_out)
    );

    // maintenance channel copied onto every pair
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            eoc_valid_out <= 1'b0;
            eoc_out       <= {(NPAIRS*8){1'b0}};
        end else begin
            eoc_valid_out <= eoc_valid_in;
            eoc_out       <= {NPAIRS{eoc_in}};
        end
    end

    // loopback: requested by the application, gated by the master
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            loopback_out <= {NPAIRS{1'b0}};
        end else begin
            loopback_out <= {NPAIRS{loopback_req_in & is_master &
                                    ctrl[`PFM_CTRL_LOOP_BIT]}};
        end
    end

    // section state from activation, identification and failures
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            operational_out <= 1'b0;
        end else begin
            operational_out <= (&activated_in) && (&pair_id_ok_in) &&
                               !any_fail && !(|signal_loss_in) &&
                               !(|frame_alignment_loss_in);
        end
    end

    // status word and read mux
    always @* begin
        status_word = 32'h0000_0000;
        status_word[`PFM_STAT_FAIL_LO +: NPAIRS] = fail;
        status_word[`PFM_STAT_OPER_BIT]           = operational_out;
        status_word[`PFM_STAT_SWL_LO +: NPAIRS]  = swl_seen;
        case (avs_address_in)
            `PFM_OFS_CTRL:   rd_word = ctrl;
            `PFM_OFS_STATUS: rd_word = status_word;
            `PFM_OFS_PRIO:   rd_word = prio;
            `PFM_OFS_MAP:    rd_word = map_out;
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    // byte-lane merge of write data
    always @* begin : merge
        integer b;
        next_ctrl = ctrl;
        next_prio = prio;
        for (b = 0; b < 4; b = b + 1) begin
            if (avs_byteenable_in[b]) begin
                next_ctrl[b*8 +: 8] = avs_writedata_in[b*8 +: 8];
                next_prio[b*8 +: 8] = avs_writedata_in[b*8 +: 8];
            end
        end
    end

    // write-one clear of sticky bits
    always @* begin
        swl_clear = {NPAIRS{1'b0}};
        if (avs_write_in && !avs_waitrequest_out &&
            avs_address_in == `PFM_OFS_STATUS) begin
            swl_clear = avs_writedata_in[`PFM_STAT_SWL_LO +: NPAIRS];
        end
    end

    // bus handshake: one wait cycle
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else if (bus_req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= avs_read_in ? rd_word : 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // writes land on the edge ending the cycle with waitrequest low, ending the access
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl <= `PFM_CTRL_RESET;
            prio <= `PFM_PRIO_RESET;
        end else if (avs_write_in && !avs_waitrequest_out) begin
            if (avs_address_in == `PFM_OFS_CTRL) begin
                ctrl <= next_ctrl & 32'h0000_001F;
            end
            if (avs_address_in == `PFM_OFS_PRIO) begin
                prio <= next_prio;
            end
        end
    end
endmodule
`default_nettype wire

// ==== pfm_xcvr_model.sv ====
// Purpose: per-pair transceiver model
// Assumes: faults driven on the clock edge
// Notes:   a cut pair needs a start-up attempt
`timescale 1ns/1ns
`default_nettype none
module pfm_xcvr_model #(
    parameter NP       = 3,
    parameter UP_DELAY = 3
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          resetn_in,
    // faults commanded by the bench
    input  wire logic [NP-1:0] cut_los_in,
    input  wire logic [NP-1:0] cut_lfa_in,
    input  wire logic [NP-1:0] noise_in,
    input  wire logic [NP-1:0] id_bad_in,
    // start-up attempts from the block
    input  wire logic [NP-1:0] startup_req_in,
    // activation flags towards the block
    output wire logic [NP-1:0] signal_loss_out,
    output wire logic [NP-1:0] frame_alignment_loss_out,
    output wire logic [NP-1:0] sync_word_loss_out,
    output wire logic [NP-1:0] pair_id_ok_out,
    output logic      [NP-1:0] activated_out
);
    logic [3:0] up_cnt [NP]; // cycles since attempt
    assign signal_loss_out = cut_los_in;
    assign frame_alignment_loss_out = cut_lfa_in;
    assign sync_word_loss_out = noise_in;
    assign pair_id_ok_out = ~id_bad_in;
    // cut drops, attempt restores
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            activated_out <= {NP{1'b1}};
            for (int i = 0; i < NP; i++) up_cnt[i] <= 4'h0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (cut_los_in[i] || cut_lfa_in[i]) begin
                    activated_out[i] <= 1'b0;
                    up_cnt[i] <= 4'h0;
                end else if (up_cnt[i] == UP_DELAY) begin
                    activated_out[i] <= 1'b1;
                    up_cnt[i] <= 4'h0;
                end else if (up_cnt[i] != 4'h0 || (startup_req_in[i] && !activated_out[i])) begin
                    up_cnt[i] <= up_cnt[i] + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire
